// ===== break_pkg.sv
package break_pkg;

   // Register addresses
   localparam logic [31:0] QUAL_B_ADDR    = 32'h0FFFFF68;
   localparam logic [31:0] CTRL_ADDR      = 32'hFFFFFF78;
   localparam logic [31:0] MASK_B_LO_ADDR = 32'hFFFFFF76;
   localparam logic [31:0] IRQ_STAT_ADDR  = 32'hFFFFFF60;
   localparam logic [31:0] IRQ_MASK_ADDR  = 32'hFFFFFF62;

   // Reset values
   localparam logic [15:0] MASK_B_LO_RST = 16'h0000;
   localparam logic [7:0]  QUAL_B_RST    = 8'h00;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [3:0]  IRQ_RST       = 4'h0;

   // Qualifier field positions
   localparam int QB_ORIGIN = 6;
   localparam int QB_KIND   = 4;
   localparam int QB_DIR    = 2;
   localparam int QB_SIZE   = 0;

   // Control bit positions
   localparam int CB_FLAG_PA = 15;
   localparam int CB_FLAG_XA = 14;
   localparam int CB_EXT     = 13;
   localparam int CB_MODE    = 12;
   localparam int CB_AFTER_A = 10;
   localparam int CB_FLAG_PB = 7;
   localparam int CB_FLAG_XB = 6;
   localparam int CB_CHAIN   = 4;
   localparam int CB_DATA_B  = 3;
   localparam int CB_AFTER_B = 2;

   // Writable plain control bits; flags handled apart
   localparam logic [15:0] CTRL_RW_MASK = 16'h341C;

   // Event order in interrupt status and mask
   localparam int EV_PA = 3;
   localparam int EV_XA = 2;
   localparam int EV_PB = 1;
   localparam int EV_XB = 0;

   typedef enum logic [1:0] {
      SZ_ANY  = 2'h0,
      SZ_BYTE = 2'h1,
      SZ_WORD = 2'h2,
      SZ_LONG = 2'h3
   } size_sel_t;

   typedef struct packed {
      logic        valid;
      logic        cpu;
      logic        fetch;
      logic        write;
      logic        external;
      size_sel_t   size;
      logic [15:0] data;
   } bus_cycle_t;

endpackage

// ===== bus_break_channel_b_control.sv
`timescale 1ns/100ps

// Summary of operation
// - Set low mask bit removes that channel B data bit from comparison.
// - Origin field: 00 off, 01 processor, 10 peripheral, 11 both.
// - Kind field: 00 off, 01 fetch, 10 data access, 11 both.
// - Direction field: 00 off, 01 read, 10 write, 11 both.
// - Size field: 00 ignore size, else byte, word or longword only.
// - Channel A processor match sets its flag and raises interrupt while sequence bit clear.
// - Channel A peripheral match sets its flag and raises interrupt while sequence bit clear.
// - Channel B processor match sets its flag and raises interrupt.
// - Channel B peripheral match sets its flag and raises interrupt.
// - External bus cycles are evaluated only while enable bit set.
// - Mode bit clear gives legacy mode, set gives extended mode.
// - Channel A fetch break before execution, or after when bit set in extended mode.
// - Sequence bit set requires channel A match before channel B.
// - Data comparison joins channel B only while data enable set.
// - Channel B fetch break before execution, or after when bit set in extended mode.
module bus_break_channel_b_control
   import break_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [31:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Observed bus cycle
   input  wire bus_cycle_t  cycle,
   input  wire logic        insn_done,
   // Compare results from neighbouring registers
   input  wire logic        chan_a_match,
   input  wire logic        chan_b_addr_match,
   input  wire logic        chan_b_data_hi_match,
   input  wire logic [15:0] chan_b_compare_data,
   // Break outputs
   output logic             break_before,
   output logic             break_after,
   output logic             break_irq
);

   logic [15:0] mask_b_lo_q;
   logic [7:0]  qual_b_q;
   logic [15:0] ctrl_q;
   logic        flag_pa_q, flag_xa_q, flag_pb_q, flag_xb_q;
   logic [3:0]  irq_stat_q, irq_mask_q, irq_stat_d;
   logic        chain_armed_q;
   logic        after_pend_q;
   logic [15:0] reg_rdata_q;
   logic        break_before_q, break_after_q, break_irq_q;

   logic        sel_qual, sel_ctrl, sel_mask, sel_stat, sel_imsk;
   logic        ext_ok, native, chain;
   logic        a_hit, b_hit;
   logic        b_origin_ok, b_kind_ok, b_dir_ok, b_size_ok, b_data_ok;
   logic [1:0]  origin_sel, kind_sel, dir_sel;
   size_sel_t   size_sel;
   logic [3:0]  ev;
   logic        a_after, b_after;

   assign sel_qual = (reg_addr == QUAL_B_ADDR);
   assign sel_ctrl = (reg_addr == CTRL_ADDR);
   assign sel_mask = (reg_addr == MASK_B_LO_ADDR);
   assign sel_stat = (reg_addr == IRQ_STAT_ADDR);
   assign sel_imsk = (reg_addr == IRQ_MASK_ADDR);

   assign origin_sel = qual_b_q[QB_ORIGIN +: 2];
   assign kind_sel   = qual_b_q[QB_KIND +: 2];
   assign dir_sel    = qual_b_q[QB_DIR +: 2];
   assign size_sel   = size_sel_t'(qual_b_q[QB_SIZE +: 2]);

   assign native = ctrl_q[CB_MODE];
   assign chain  = ctrl_q[CB_CHAIN];
   // External cycles pass only when enabled
   assign ext_ok = cycle.valid && (!cycle.external
                   || ctrl_q[CB_EXT]);

   // Channel B qualifiers; 00 in any of the first three disables it
   assign b_origin_ok = cycle.cpu ? origin_sel[0]
                                  : origin_sel[1];
   assign b_kind_ok   = cycle.fetch ? kind_sel[0]
                                    : kind_sel[1];
   assign b_dir_ok    = cycle.write ? dir_sel[1]
                                    : dir_sel[0];
   assign b_size_ok   = (size_sel == SZ_ANY)
                        || (size_sel == cycle.size);
   // Masked bits never mismatch
   assign b_data_ok   = (((cycle.data ^ chan_b_compare_data)
                          & ~mask_b_lo_q) == 16'h0000)
                        && chan_b_data_hi_match;

   assign a_hit = ext_ok && chan_a_match;
   assign b_hit = ext_ok && chan_b_addr_match && b_origin_ok
                  && b_kind_ok && b_dir_ok && b_size_ok
                  && (!ctrl_q[CB_DATA_B] || b_data_ok);

   // In chained mode channel A only arms channel B
   always_comb begin
      ev = 4'h0;
      if (a_hit && !chain) begin
         ev[EV_PA] = cycle.cpu;
         ev[EV_XA] = !cycle.cpu;
      end
      if (b_hit && (!chain || chain_armed_q)) begin
         ev[EV_PB] = cycle.cpu;
         ev[EV_XB] = !cycle.cpu;
      end
   end

   // Legacy mode keeps every break ahead of execution
   assign a_after = native && ctrl_q[CB_AFTER_A] && cycle.fetch;
   assign b_after = native && ctrl_q[CB_AFTER_B] && cycle.fetch;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         chain_armed_q <= 1'b0;
      end else if (chain && b_hit && chain_armed_q) begin
         chain_armed_q <= 1'b0;
      end else if (chain && a_hit) begin
         chain_armed_q <= 1'b1;
      end else if (!chain) begin
         chain_armed_q <= 1'b0;
      end
   end

   // Break placement
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         break_before_q <= 1'b0;
         break_after_q  <= 1'b0;
         after_pend_q   <= 1'b0;
      end else begin
         break_before_q <= ((ev[EV_PA] | ev[EV_XA]) && !a_after)
                           || ((ev[EV_PB] | ev[EV_XB]) && !b_after);
         if (((ev[EV_PA] | ev[EV_XA]) && a_after)
             || ((ev[EV_PB] | ev[EV_XB]) && b_after)) begin
            after_pend_q <= 1'b1;
         end else if (insn_done) begin
            after_pend_q <= 1'b0;
         end
         break_after_q <= after_pend_q && insn_done;
      end
   end

   // Plain registers; reserved bits are never stored
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mask_b_lo_q <= MASK_B_LO_RST;
         qual_b_q    <= QUAL_B_RST;
         ctrl_q      <= CTRL_RST;
         irq_mask_q  <= IRQ_RST;
      end else if (reg_wr) begin
         if (sel_mask) begin
            mask_b_lo_q <= reg_wdata;
         end else if (sel_qual) begin
            qual_b_q <= reg_wdata[7:0];
         end else if (sel_ctrl) begin
            ctrl_q <= reg_wdata & CTRL_RW_MASK;
         end else if (sel_imsk) begin
            irq_mask_q <= reg_wdata[3:0];
         end
      end
   end

   // Flags clear on a written zero; a new match wins the cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         flag_pa_q <= 1'b0;
         flag_xa_q <= 1'b0;
         flag_pb_q <= 1'b0;
         flag_xb_q <= 1'b0;
      end else begin
         flag_pa_q <= ev[EV_PA] | (flag_pa_q
                      & !(reg_wr && sel_ctrl && !reg_wdata[CB_FLAG_PA]));
         flag_xa_q <= ev[EV_XA] | (flag_xa_q
                      & !(reg_wr && sel_ctrl && !reg_wdata[CB_FLAG_XA]));
         flag_pb_q <= ev[EV_PB] | (flag_pb_q
                      & !(reg_wr && sel_ctrl && !reg_wdata[CB_FLAG_PB]));
         flag_xb_q <= ev[EV_XB] | (flag_xb_q
                      & !(reg_wr && sel_ctrl && !reg_wdata[CB_FLAG_XB]));
      end
   end

   // Interrupt status, write one to clear, set wins
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (reg_wr && sel_stat) begin
         irq_stat_d = irq_stat_q & ~reg_wdata[3:0];
      end
      irq_stat_d = irq_stat_d | ev;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq_stat_q  <= IRQ_RST;
         break_irq_q <= 1'b0;
      end else begin
         irq_stat_q  <= irq_stat_d;
         break_irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   // Read data valid in the cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         if (sel_mask) begin
            reg_rdata_q <= mask_b_lo_q;
         end else if (sel_qual) begin
            reg_rdata_q <= {8'h00, qual_b_q};
         end else if (sel_ctrl) begin
            reg_rdata_q <= ctrl_q | {flag_pa_q, flag_xa_q, 6'h00,
                                     flag_pb_q, flag_xb_q, 6'h00};
         end else if (sel_stat) begin
            reg_rdata_q <= {12'h000, irq_stat_q};
         end else if (sel_imsk) begin
            reg_rdata_q <= {12'h000, irq_mask_q};
         end else begin
            reg_rdata_q <= 16'h0000;
         end
      end else begin
         reg_rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata    = reg_rdata_q;
   assign break_before = break_before_q;
   assign break_after  = break_after_q;
   assign break_irq    = break_irq_q;

   // Checks
   a_mask_excludes: assert property (@(posedge core_clk) disable iff (!reset_n)
      (cycle.valid && !cycle.external && chan_b_addr_match
       && ctrl_q[CB_DATA_B] && qual_b_q == 8'hFC && chan_b_data_hi_match
       && !chain && mask_b_lo_q == 16'hFFFF)
      |=> flag_pb_q || flag_xb_q)
      else $error("fully masked data failed to match");
   a_origin_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      (origin_sel == 2'h0) |-> !ev[EV_PB] && !ev[EV_XB])
      else $error("channel B fired with origin off");
   a_kind_select: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ev[EV_PB] || ev[EV_XB]) |-> (cycle.fetch ? kind_sel[0]
                                    : kind_sel[1]))
      else $error("channel B fired on wrong access kind");
   a_dir_select: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ev[EV_PB] || ev[EV_XB]) |-> (cycle.write ? dir_sel[1]
                                    : dir_sel[0]))
      else $error("channel B fired on wrong direction");
   a_size_select: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ev[EV_PB] && size_sel != SZ_ANY) |-> size_sel == cycle.size)
      else $error("channel B fired on wrong size");
   a_flag_a_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (a_hit && !chain && cycle.cpu) |=> flag_pa_q
      ##0 irq_stat_q[EV_PA])
      else $error("channel A processor flag not set");
   a_flag_xa_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      (a_hit && !chain && !cycle.cpu) |=> flag_xa_q)
      else $error("channel A peripheral flag not set");
   a_flag_b_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      ev[EV_PB] |=> flag_pb_q && irq_stat_q[EV_PB])
      else $error("channel B processor flag not set");
   a_flag_xb_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      ev[EV_XB] |=> flag_xb_q)
      else $error("channel B peripheral flag not set");
   a_ext_ignored: assert property (@(posedge core_clk) disable iff (!reset_n)
      (cycle.external && !ctrl_q[CB_EXT]) |-> ev == 4'h0)
      else $error("external cycle matched while disabled");
   a_legacy_before: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!native && ev != 4'h0) |=> break_before_q)
      else $error("legacy mode break not placed before");
   a_after_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
      (after_pend_q && !insn_done) |=> !break_after_q)
      else $error("after break fired before execution");
   a_chain_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      (chain && !chain_armed_q) |-> !ev[EV_PB] && !ev[EV_XB])
      else $error("chained channel B fired unarmed");
   a_data_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ctrl_q[CB_DATA_B] && !b_data_ok) |-> !b_hit)
      else $error("channel B hit despite data mismatch");
   a_after_b: assert property (@(posedge core_clk) disable iff (!reset_n)
      (ev[EV_PB] && b_after && !(ev[EV_PA] || ev[EV_XA])) |=> after_pend_q
      && !break_before_q)
      else $error("channel B after break misplaced");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      (flag_pb_q && !(reg_wr && sel_ctrl)) |=> flag_pb_q)
      else $error("channel B flag dropped without write");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reg_rd && sel_qual) |-> reg_rdata_q[15:8] == 8'h00)
      else $error("reserved qualifier bits read nonzero");
   a_irq_raised: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ((irq_stat_q & irq_mask_q) != 4'h0 && !(reg_wr && (sel_stat || sel_imsk)))
      |=> break_irq_q)
      else $error("interrupt low with unmasked status set");
   a_irq_quiet: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ((irq_stat_q & irq_mask_q) == 4'h0 && ev == 4'h0) |=> !break_irq_q)
      else $error("interrupt high with nothing pending");
   a_before_idle: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (ev == 4'h0) |=> !break_before_q)
      else $error("before break without a match");
   a_after_fire: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (after_pend_q && insn_done) |=> break_after_q)
      else $error("pending after break not taken");
   a_flag_pb_clear: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (flag_pb_q && !ev[EV_PB] && reg_wr && sel_ctrl
       && !reg_wdata[CB_FLAG_PB]) |=> !flag_pb_q)
      else $error("channel B flag not cleared by zero write");
   a_flag_pa_clear: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (flag_pa_q && !ev[EV_PA] && reg_wr && sel_ctrl
       && !reg_wdata[CB_FLAG_PA]) |=> !flag_pa_q)
      else $error("channel A flag not cleared by zero write");
   a_ctrl_reserved: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (reg_rd && sel_ctrl) |=> (reg_rdata_q & 16'h0B23) == 16'h0000)
      else $error("reserved control bits read nonzero");
   a_unmapped_zero: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (reg_rd && !(sel_qual || sel_ctrl || sel_mask || sel_stat || sel_imsk))
      |=> reg_rdata_q == 16'h0000)
      else $error("unmapped address read nonzero");
   a_rdata_idle: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !reg_rd |=> reg_rdata_q == 16'h0000)
      else $error("read data nonzero without a read");
   a_ext_passes: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (cycle.valid && cycle.external && ctrl_q[CB_EXT] && chan_b_addr_match
       && qual_b_q == 8'hFC && !ctrl_q[CB_DATA_B] && !chain)
      |-> ev[EV_PB] || ev[EV_XB])
      else $error("enabled external cycle did not match");
   a_chain_disarm: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (chain && chain_armed_q && b_hit) |=> !chain_armed_q)
      else $error("chain stayed armed after channel B match");
   a_chain_no_a: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      chain |-> !ev[EV_PA] && !ev[EV_XA])
      else $error("channel A fired in chained mode");
   a_pb_origin: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ev[EV_PB] |-> cycle.cpu && origin_sel[0])
      else $error("channel B processor event on wrong origin");
   a_xb_origin: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ev[EV_XB] |-> !cycle.cpu && origin_sel[1])
      else $error("channel B peripheral event on wrong origin");
   a_mask_write: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (reg_wr && sel_mask) |=> mask_b_lo_q == $past(reg_wdata))
      else $error("low data mask write lost");

endmodule

// ===== cpu_bus_model.sv
`timescale 1ns/100ps

module cpu_bus_model
   import break_pkg::*;
(
   // Clock
   input  wire logic       core_clk,
   // Requests from the bench
   input  wire bus_cycle_t req,
   input  wire logic       req_go,
   input  wire logic       done_req,
   // Observed bus
   output bus_cycle_t      cycle,
   output logic            insn_done
);
   bus_cycle_t junk;

   // Idle bus shows the inverted request so stale values never look valid
   always @(posedge core_clk) begin
      junk = ~req;
      junk.valid = 1'b0;
      if (req_go) begin
         cycle <= req;
      end else begin
         cycle <= junk;
      end
      insn_done <= done_req;
   end
endmodule

// ===== bus_break_channel_b_control_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
   end \
end

module bus_break_channel_b_control_tb
   import break_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [31:0] reg_addr = '0;
   logic [15:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   bus_cycle_t  req = '0;
   bus_cycle_t  cycle;
   bus_cycle_t  c;
   logic        req_go = 1'b0;
   logic        done_req = 1'b0;
   logic        insn_done;
   logic        a_hit = 1'b0;
   logic        b_hit = 1'b0;
   logic [15:0] cmp_data = '0;
   logic        hi_ok = 1'b1;
   logic        brk_bef;
   logic        brk_aft;
   logic        irq;
   logic [15:0] ctl;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   // Channel B table: qualifier, {cpu,fetch,write,size}, flags {proc,periph}
   logic [7:0]  tq [13] = '{8'hFC, 8'hFC, 8'h7C, 8'hBC, 8'h3C, 8'hDC,
      8'hEC, 8'hF4, 8'hF8, 8'hFD, 8'hFD, 8'hFE, 8'hFF};
   logic [4:0]  tc [13] = '{5'h11, 5'h01, 5'h01, 5'h01, 5'h11, 5'h11,
      5'h11, 5'h15, 5'h15, 5'h12, 5'h11, 5'h12, 5'h13};
   logic [1:0]  te [13] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0,
      2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2};

   always #2 core_clk = ~core_clk;

   bus_break_channel_b_control dut (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cycle(cycle), .insn_done(insn_done),
      .chan_a_match(a_hit), .chan_b_addr_match(b_hit),
      .chan_b_data_hi_match(hi_ok), .chan_b_compare_data(cmp_data),
      .break_before(brk_bef), .break_after(brk_aft), .break_irq(irq));

   cpu_bus_model bus_src (
      .core_clk(core_clk), .req(req), .req_go(req_go),
      .done_req(done_req), .cycle(cycle), .insn_done(insn_done));

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask

   // Bus cycle reaches the block one cycle after the request
   task automatic hit(input bus_cycle_t b, input logic a, input logic m,
                      input logic e);
      @(posedge core_clk);
      req <= b;
      req_go <= 1'b1;
      @(posedge core_clk);
      req_go <= 1'b0;
      a_hit <= a;
      b_hit <= m;
      @(posedge core_clk);
      a_hit <= 1'b0;
      b_hit <= 1'b0;
      #1;
      `CHK("break_before", e, brk_bef)
   endtask

   task automatic done_chk(input logic e);
      @(posedge core_clk);
      done_req <= 1'b1;
      @(posedge core_clk);
      done_req <= 1'b0;
      @(posedge core_clk);
      #1;
      `CHK("break_after", e, brk_aft)
   endtask

   task automatic irq_chk(input logic e);
      @(posedge core_clk);
      #1;
      `CHK("break_irq", e, irq)
   endtask

   task automatic clr();
      wr(CTRL_ADDR, ctl);
      wr(IRQ_STAT_ADDR, 16'h000F);
   endtask

   function automatic bus_cycle_t mk(input logic [4:0] k,
                                     input logic [15:0] d);
      mk = '0;
      mk.valid = 1'b1;
      mk.cpu = k[4];
      mk.fetch = k[3];
      mk.write = k[2];
      mk.size = size_sel_t'(k[1:0]);
      mk.data = d;
   endfunction

   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      rd_chk(MASK_B_LO_ADDR, 16'h0000);
      rd_chk(QUAL_B_ADDR, 16'h0000);
      rd_chk(CTRL_ADDR, 16'h0000);
      rd_chk(32'hFFFFFF7A, 16'h0000);
      wr(QUAL_B_ADDR, 16'hFFFF);
      rd_chk(QUAL_B_ADDR, 16'h00FF);
      wr(CTRL_ADDR, 16'hFFFF);
      rd_chk(CTRL_ADDR, 16'h341C);
      ctl = 16'h0000;
      wr(CTRL_ADDR, ctl);
      // Channel A with interrupt masked, then unmasked
      hit(mk(5'h11, 16'h0000), 1'b1, 1'b0, 1'b1);
      irq_chk(1'b0);
      hit(mk(5'h11, 16'h0000), 1'b0, 1'b0, 1'b0);
      rd_chk(CTRL_ADDR, 16'h8000);
      rd_chk(IRQ_STAT_ADDR, 16'h0008);
      wr(IRQ_MASK_ADDR, 16'h000F);
      irq_chk(1'b1);
      wr(IRQ_STAT_ADDR, 16'h0008);
      irq_chk(1'b0);
      wr(CTRL_ADDR, ctl);
      rd_chk(CTRL_ADDR, 16'h0000);
      hit(mk(5'h01, 16'h0000), 1'b1, 1'b0, 1'b1);
      rd_chk(CTRL_ADDR, 16'h4000);
      clr();
      // Channel B qualifier codes
      for (int i = 0; i < 13; i++) begin
         wr(QUAL_B_ADDR, {8'h00, tq[i]});
         hit(mk(tc[i], 16'h0000), 1'b0, 1'b1, |te[i]);
         rd_chk(CTRL_ADDR, {8'h00, te[i], 6'h00});
         clr();
      end
      // External bus cycles
      wr(QUAL_B_ADDR, 16'h00FC);
      c = mk(5'h11, 16'h0000);
      c.external = 1'b1;
      hit(c, 1'b0, 1'b1, 1'b0);
      ctl = 16'h2000;
      wr(CTRL_ADDR, ctl);
      hit(c, 1'b0, 1'b1, 1'b1);
      // Data comparison with low mask
      ctl = 16'h0008;
      clr();
      cmp_data <= 16'h1234;
      wr(MASK_B_LO_ADDR, 16'h00FF);
      hit(mk(5'h11, 16'h12AB), 1'b0, 1'b1, 1'b1);
      hit(mk(5'h11, 16'h13AB), 1'b0, 1'b1, 1'b0);
      hi_ok <= 1'b0;
      hit(mk(5'h11, 16'h12AB), 1'b0, 1'b1, 1'b0);
      hi_ok <= 1'b1;
      wr(MASK_B_LO_ADDR, 16'hFFFF);
      hit(mk(5'h11, 16'h5555), 1'b0, 1'b1, 1'b1);
      wr(MASK_B_LO_ADDR, 16'h0000);
      hit(mk(5'h11, 16'h12AB), 1'b0, 1'b1, 1'b0);
      // Fetch break placement and mode
      ctl = 16'h1004;
      clr();
      hit(mk(5'h19, 16'h0000), 1'b0, 1'b1, 1'b0);
      done_chk(1'b1);
      ctl = 16'h0004;
      clr();
      hit(mk(5'h19, 16'h0000), 1'b0, 1'b1, 1'b1);
      done_chk(1'b0);
      ctl = 16'h1400;
      clr();
      hit(mk(5'h19, 16'h0000), 1'b1, 1'b0, 1'b0);
      done_chk(1'b1);
      // Chained A then B
      ctl = 16'h0010;
      clr();
      hit(mk(5'h11, 16'h0000), 1'b0, 1'b1, 1'b0);
      hit(mk(5'h11, 16'h0000), 1'b1, 1'b0, 1'b0);
      rd_chk(CTRL_ADDR, 16'h0010);
      hit(mk(5'h11, 16'h0000), 1'b0, 1'b1, 1'b1);
      rd_chk(CTRL_ADDR, 16'h0090);
      finish_test();
   end
endmodule
